// File: include/spac_pkg.sv
// Shared constants and types for the self-program access control block.
// Assumes an APB master on pclk and a flash/EEPROM back end on the same clock.
package spac_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] OFS_CTRL  = 8'h00; // memory_access_control
  localparam logic [7:0] OFS_KEY   = 8'h04; // unlock_key_port
  localparam logic [7:0] OFS_LATCH = 8'h08; // byte_transfer_latch
  localparam logic [7:0] OFS_PTRL  = 8'h0C; // pointer_low_byte
  localparam logic [7:0] OFS_PTRH  = 8'h10; // pointer_high_byte
  localparam logic [7:0] OFS_PTRU  = 8'h14; // pointer_upper_byte
  localparam logic [7:0] OFS_DONE  = 8'h18; // peripheral_flag_reg_four image
  localparam logic [7:0] OFS_TOP   = 8'h1C; // table operation command

  // Control register bit positions
  localparam int unsigned B_PGM   = 7;
  localparam int unsigned B_CFG   = 6;
  localparam int unsigned B_FREE  = 4;
  localparam int unsigned B_ABORT = 3;
  localparam int unsigned B_WRITE_PERMIT  = 2;
  localparam int unsigned B_WR    = 1;
  localparam int unsigned B_RD    = 0;

  // Done flag position in the flag register image
  localparam int unsigned B_DONE = 6;

  // Table command fields: mode in [1:0], direction in bit 2
  localparam int unsigned B_TDIR = 2;

  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Widths and reset values
  localparam int unsigned PTR_W   = 22;
  localparam int unsigned HOLD_N  = 64;
  localparam logic [7:0]  HOLD_RST = 8'hFF;
  localparam logic        ABORT_RST = 1'b1;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Pointer update behaviour of a table operation
  typedef enum logic [1:0] {
    SPAC_PTR_KEEP = 2'h0,
    SPAC_PTR_POST_INC = 2'h1,
    SPAC_PTR_POST_DEC = 2'h2,
    SPAC_PTR_PRE_INC = 2'h3
  } spac_ptr_mode_t;

  // Target space of a timed cycle
  typedef enum logic [1:0] {
    SPAC_SP_EEPROM = 2'h0,
    SPAC_SP_FLASH  = 2'h1,
    SPAC_SP_CONFIG = 2'h2
  } spac_space_t;

  // Main sequencer, Gray coded along idle -> read wait / idle -> busy
  typedef enum logic [1:0] {
    SPAC_IDLE    = 2'b00,
    SPAC_RD_WAIT = 2'b01,
    SPAC_BUSY    = 2'b10
  } spac_state_t;

  // Command toward the programming timer and charge pump
  typedef struct packed {
    logic          start;
    logic          erase;
    spac_space_t   space;
    logic [15:0]   block;
  } spac_prog_cmd_t;

  // APB response bundle
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spac_apb_rsp_t;

endpackage

// File: src/spac_access_ctrl.sv
// Self-program access control: control bits, unlock key, table latch,
// table pointer and 64 holding bytes, reached over APB.
// Assumes flash read data and programming completion come from logic on pclk.
// Summary of operation
// R1: Unlock key port unstored, reads zero
// R2: Program select one targets flash, else EEPROM
// R3: Config select overrides program select
// R4: Row erase on next start, self clears
// R5: Write permit zero at reset blocks cycles
// R6: Abort flag set on start, cleared on completion
// R7: Abort keeps both space select bits; reset sets abort but clears both selects to zero
// R8: Start bit set-only, hardware clears at end
// R9: Done flag set at completion, software clears
// R10: Read start lasts one cycle, self clears
// R11: Read start ignored for flash or config
// R12: Control bit five reads zero
// R13: Eight-bit latch holds each moved byte
// R14: 22-bit pointer from three byte registers
// R15: Four pointer update behaviours
// R16: Auto update touches low 21 bits only
// R17: Table read uses all 22 bits
// R18: Table write picks holding byte by bits 5:0
// R19: Program write block from bits 21:6
// R20: Erase block from bits 21:6, low ignored
// R21: Software writes 55h then AAh first
// R22: Holding bytes reset to FFh, after writes
// R23: Core stalls during flash cycles
// R24: Start without permit or unlock aborts
`timescale 1ns/1ns
`default_nettype none

module spac_access_ctrl
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [21:0]                  flash_rd_addr,
  input  wire logic [7:0]              flash_rd_data,
  output spac_pkg::spac_prog_cmd_t     prog_cmd,
  input  wire logic                    prog_done,
  output logic [511:0]                 hold_bytes,
  output logic                         eeprom_rd_strobe,
  output logic                         cpu_stall,
  output logic                         nvm_done_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  // One record holds every flop of the block; one comb process builds
  // its next value and one flop process registers it, so no field can
  // pick up a second driver by accident.

  typedef struct packed {
    spac_pkg::spac_state_t    state;
    logic                     pgm_sel;
    logic                     cfg_sel;
    logic                     free;
    logic                     abort;
    logic                     write_permit;
    logic                     wr;
    logic                     rd;
    logic                     key_first;
    logic                     armed;
    logic                     done;
    logic [7:0]               latch;
    logic [21:0]              ptr;
    logic [21:0]              rd_addr;
    spac_pkg::spac_ptr_mode_t rd_mode;
    spac_pkg::spac_prog_cmd_t cmd;
    logic                     flash_cyc;
    logic [63:0][7:0]         hold;
    logic [31:0]              rdata;
  } spac_state_rec_t;

  spac_state_rec_t s_ff;
  spac_state_rec_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Step of the pointer; the top bit stays put
  // Wrap happens inside the low 21 bits, so a walk off the end of program
  // space never spills into the ID and configuration area.
  function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic down);
    logic [20:0] low;
    low = down ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001; // R16
    return {p[21], low};
  endfunction

  // Pointer used by the access itself
  // Only pre-increment moves the pointer before the byte is touched
  function automatic logic [21:0] ptr_use(input logic [21:0] p,
                                          input spac_pkg::spac_ptr_mode_t m);
    return (m == spac_pkg::SPAC_PTR_PRE_INC) ? ptr_step(p, 1'b0) : p; // R15
  endfunction

  // Pointer left after the access
  function automatic logic [21:0] ptr_after(input logic [21:0] p,
                                            input spac_pkg::spac_ptr_mode_t m);
    logic [21:0] r;
    case (m)
      spac_pkg::SPAC_PTR_POST_INC: r = ptr_step(p, 1'b0); // R15
      spac_pkg::SPAC_PTR_POST_DEC: r = ptr_step(p, 1'b1); // R15
      spac_pkg::SPAC_PTR_PRE_INC:  r = ptr_step(p, 1'b0); // R15
      default:                     r = p;
    endcase
    return r;
  endfunction

  // Space chosen by the two select bits
  // Config select wins, whatever the program select holds
  function automatic spac_pkg::spac_space_t space_of(input logic pgm, input logic cfg);
    spac_pkg::spac_space_t sp;
    if (cfg)
      sp = spac_pkg::SPAC_SP_CONFIG; // R3
    else if (pgm)
      sp = spac_pkg::SPAC_SP_FLASH; // R2
    else
      sp = spac_pkg::SPAC_SP_EEPROM; // R2
    return sp;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode and handshake

  // Decode and handshake terms shared by both comb processes
  logic                     acc;
  logic                     wr_acc;
  logic                     setup;
  logic                     mapped;
  logic                     top_rd_req;
  logic                     stall_now;
  spac_pkg::spac_ptr_mode_t wmode;

  assign wmode  = spac_pkg::spac_ptr_mode_t'(pwdata[1:0]);
  assign setup  = psel && !penable;
  assign mapped = (paddr == spac_pkg::OFS_CTRL)  || (paddr == spac_pkg::OFS_KEY)  ||
                  (paddr == spac_pkg::OFS_LATCH) || (paddr == spac_pkg::OFS_PTRL) ||
                  (paddr == spac_pkg::OFS_PTRH)  || (paddr == spac_pkg::OFS_PTRU) ||
                  (paddr == spac_pkg::OFS_DONE)  || (paddr == spac_pkg::OFS_TOP);

  // Flash and config cycles hold the core off the bus until the timer ends
  // EEPROM cycles leave the bus free, so software may poll while they run
  assign stall_now = (s_ff.state == spac_pkg::SPAC_BUSY) && s_ff.flash_cyc; // R23

  // A table read needs one wait state for the flash data to return
  // Trades one bus cycle for a registered, glitch-free array address
  assign top_rd_req = psel && penable && pwrite && (paddr == spac_pkg::OFS_TOP) &&
                      !pwdata[spac_pkg::B_TDIR] && (s_ff.state == spac_pkg::SPAC_IDLE);

  // Ready handshake
  // Unmapped offsets still complete at once, flagged by pslverr
  always_comb
  begin
    pready  = !(stall_now || top_rd_req);
    pslverr = psel && penable && pready && !mapped;
  end

  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  // Default holds every field except cmd.start, which drops to zero; only the branches below move anything else

  always_comb
  begin
    logic                  go_ok;
    logic                  new_pgm;
    logic                  new_cfg;
    logic                  new_write_permit;
    logic [21:0]           p;
    nxt_s = s_ff;
    go_ok    = 1'b0;
    new_pgm  = pwdata[spac_pkg::B_PGM];
    new_cfg  = pwdata[spac_pkg::B_CFG];
    new_write_permit = pwdata[spac_pkg::B_WRITE_PERMIT];
    p        = s_ff.ptr;
    nxt_s.cmd.start = 1'b0;

    // Read start lives for exactly one cycle
    if (s_ff.rd)
      nxt_s.rd = 1'b0; // R10

    // Read data sampled in the setup phase
    // Capture in setup keeps prdata off the combinational path; the value
    // shows the state one cycle before the access completes
    if (setup && !pwrite)
    begin
      if (paddr == spac_pkg::OFS_CTRL)
        nxt_s.rdata = {24'h000000, s_ff.pgm_sel, s_ff.cfg_sel, 1'b0, s_ff.free,
                       s_ff.abort, s_ff.write_permit, s_ff.wr, s_ff.rd}; // R12
      else if (paddr == spac_pkg::OFS_LATCH)
        nxt_s.rdata = {24'h000000, s_ff.latch};
      else if (paddr == spac_pkg::OFS_PTRL)
        nxt_s.rdata = {24'h000000, s_ff.ptr[7:0]}; // R14
      else if (paddr == spac_pkg::OFS_PTRH)
        nxt_s.rdata = {24'h000000, s_ff.ptr[15:8]}; // R14
      else if (paddr == spac_pkg::OFS_PTRU)
        nxt_s.rdata = {26'h0, s_ff.ptr[21:16]}; // R14
      else if (paddr == spac_pkg::OFS_DONE)
        nxt_s.rdata = {25'h0, s_ff.done, 6'h00};
      else
        nxt_s.rdata = spac_pkg::WORD_ZERO; // R1
    end

    // Software writes
    // Writes land only at the completing access edge; setup cycles never
    // change state
    if (wr_acc)
    begin
      if (paddr == spac_pkg::OFS_CTRL)
      begin
        nxt_s.pgm_sel = new_pgm;
        nxt_s.cfg_sel = new_cfg;
        nxt_s.write_permit    = new_write_permit; // R5
        nxt_s.abort   = pwdata[spac_pkg::B_ABORT];
        if (!s_ff.wr)
          nxt_s.free = pwdata[spac_pkg::B_FREE]; // R4
        // Start request: set-only, zero writes leave it alone
        if (pwdata[spac_pkg::B_WR] && !s_ff.wr) // R8
        begin
          if (s_ff.armed && new_write_permit) // R5 R21
            go_ok = 1'b1;
          else
            nxt_s.abort = 1'b1; // R24
        end
        // Read start refused for flash or config space
        if (pwdata[spac_pkg::B_RD] && !new_pgm && !new_cfg && !s_ff.wr) // R11
          nxt_s.rd = 1'b1; // R10
        // Any control write consumes the unlock
        // so a stray write between key bytes and start cannot reuse it
        nxt_s.armed     = 1'b0; // R24
        nxt_s.key_first = 1'b0;
      end
      else if (paddr == spac_pkg::OFS_KEY)
      begin
        // Key bytes pass straight into the unlock tracker, nothing is kept
        if (pwdata[7:0] == spac_pkg::KEY_FIRST)
        begin
          nxt_s.key_first = 1'b1; // R21
          nxt_s.armed     = 1'b0;
        end
        else
        begin
          nxt_s.armed     = s_ff.key_first && (pwdata[7:0] == spac_pkg::KEY_SECOND); // R21
          nxt_s.key_first = 1'b0;
        end
      end
      else if (paddr == spac_pkg::OFS_LATCH)
        nxt_s.latch = pwdata[7:0]; // R13
      else if (paddr == spac_pkg::OFS_PTRL)
        nxt_s.ptr[7:0] = pwdata[7:0]; // R14
      else if (paddr == spac_pkg::OFS_PTRH)
        nxt_s.ptr[15:8] = pwdata[7:0]; // R14
      else if (paddr == spac_pkg::OFS_PTRU)
        nxt_s.ptr[21:16] = pwdata[5:0]; // R14
      else if (paddr == spac_pkg::OFS_DONE)
      begin
        if (pwdata[spac_pkg::B_DONE])
          nxt_s.done = 1'b0; // R9
      end
      else if ((paddr == spac_pkg::OFS_TOP) && pwdata[spac_pkg::B_TDIR] &&
               (s_ff.state == spac_pkg::SPAC_IDLE))
      begin
        // Table write: latch byte into the holding byte picked by the pointer
        p = ptr_use(s_ff.ptr, wmode); // R15
        nxt_s.hold[p[5:0]] = s_ff.latch; // R18
        nxt_s.ptr = ptr_after(s_ff.ptr, wmode); // R15
      end
    end

    // Sequencer
    // Table read and timed start cannot both fire: a table read holds the
    // bus, so no control write completes in the same cycle
    case (s_ff.state)
      spac_pkg::SPAC_IDLE:
      begin
        if (top_rd_req)
        begin
          nxt_s.rd_mode = wmode;
          nxt_s.rd_addr = ptr_use(s_ff.ptr, wmode); // R17
          nxt_s.state   = spac_pkg::SPAC_RD_WAIT;
        end
        else if (go_ok)
        begin
          // Timed cycle: flag goes up until the timer reports completion
          nxt_s.wr        = 1'b1; // R8
          nxt_s.abort     = 1'b1; // R6
          nxt_s.cmd.start = 1'b1;
          // Erase choice comes from the same write that raises the start bit
          nxt_s.cmd.erase = pwdata[spac_pkg::B_FREE]; // R4
          nxt_s.cmd.space = space_of(new_pgm, new_cfg); // R2 R3
          nxt_s.cmd.block = s_ff.ptr[21:6]; // R19 R20
          nxt_s.flash_cyc = new_pgm || new_cfg; // R23
          nxt_s.state     = spac_pkg::SPAC_BUSY;
        end
      end
      spac_pkg::SPAC_RD_WAIT:
      begin
        // Flash byte arrives one cycle after the address
        // The array answers combinationally on the registered address
        nxt_s.latch = flash_rd_data; // R13 R17
        nxt_s.ptr   = ptr_after(s_ff.ptr, s_ff.rd_mode); // R15
        nxt_s.state = spac_pkg::SPAC_IDLE;
      end
      spac_pkg::SPAC_BUSY:
      begin
        if (prog_done)
        begin
          // Selects survive so a failure can be traced
          nxt_s.pgm_sel = s_ff.pgm_sel; // R7
          nxt_s.cfg_sel = s_ff.cfg_sel; // R7
          nxt_s.wr      = 1'b0; // R8
          nxt_s.abort   = 1'b0; // R6
          nxt_s.done    = 1'b1; // R9
          // Erase keeps the holding bytes: a write may follow with them
          if (s_ff.cmd.erase)
            nxt_s.free = 1'b0; // R4
          else
          begin
            for (int i = 0; i < spac_pkg::HOLD_N; i++)
              nxt_s.hold[i] = spac_pkg::HOLD_RST; // R22
          end
          nxt_s.state = spac_pkg::SPAC_IDLE;
        end
      end
      default:
        nxt_s.state = spac_pkg::SPAC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Holding bytes power up as FFh so an early write leaves flash untouched

  // Abort flag powers up set: a reset cannot tell an interrupted cycle apart
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff           <= '0;
      s_ff.state     <= spac_pkg::SPAC_IDLE;
      s_ff.abort     <= spac_pkg::ABORT_RST; // R6
      s_ff.write_permit      <= 1'b0; // R5
      s_ff.cmd.space <= spac_pkg::SPAC_SP_EEPROM;
      for (int i = 0; i < spac_pkg::HOLD_N; i++)
        s_ff.hold[i] <= spac_pkg::HOLD_RST; // R22
    end
    else
      s_ff <= nxt_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Stall is combinational so the core sees it in the first busy cycle

  assign prdata           = s_ff.rdata;
  assign flash_rd_addr    = s_ff.rd_addr; // R17
  assign prog_cmd         = s_ff.cmd;
  assign hold_bytes       = s_ff.hold;
  assign eeprom_rd_strobe = s_ff.rd; // R10
  assign cpu_stall        = stall_now; // R23
  assign nvm_done_flag    = s_ff.done; // R9

endmodule

`default_nettype wire

// File: testbench/spac_access_chk.sv
// Port-level assertions for the self-program access control block.
// Assumes binding onto spac_access_ctrl; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module spac_access_chk (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire spac_pkg::spac_prog_cmd_t prog_cmd,
  input wire logic                     prog_done,
  input wire logic                     eeprom_rd_strobe,
  input wire logic                     cpu_stall,
  input wire logic                     nvm_done_flag
);
  logic acc;
  // Completed transfer at this edge
  assign acc = psel && penable && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  key_reads_zero_a: assert property (acc && !pwrite && paddr == spac_pkg::OFS_KEY
    |-> prdata == 32'h0000_0000) else $error("key port read not zero");
  bit_five_zero_a: assert property (acc && !pwrite && paddr == spac_pkg::OFS_CTRL
    |-> !prdata[5]) else $error("control bit five set");
  unmapped_error_a: assert property (acc && paddr > spac_pkg::OFS_TOP |-> pslverr)
    else $error("unmapped access without error");
  start_pulse_a: assert property (prog_cmd.start |=> !prog_cmd.start)
    else $error("start longer than one cycle");
  stall_on_flash_a: assert property (prog_cmd.start
    && prog_cmd.space != spac_pkg::SPAC_SP_EEPROM |-> cpu_stall) else $error("no stall");
  busy_refuses_a: assert property (cpu_stall && psel && penable |-> !pready)
    else $error("bus answered while busy");
  done_ends_a: assert property (cpu_stall && prog_done |=> nvm_done_flag && !cpu_stall)
    else $error("completion not reported");
  done_sticky_a: assert property (nvm_done_flag
    && !(acc && pwrite && paddr == spac_pkg::OFS_DONE) |=> nvm_done_flag)
    else $error("done flag dropped");
  rd_pulse_a: assert property (eeprom_rd_strobe |=> !eeprom_rd_strobe)
    else $error("read strobe too long");
endmodule
bind spac_access_ctrl spac_access_chk spac_access_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .prog_cmd(prog_cmd), .prog_done(prog_done),
  .eeprom_rd_strobe(eeprom_rd_strobe), .cpu_stall(cpu_stall), .nvm_done_flag(nvm_done_flag));
`default_nettype wire

// File: testbench/spac_flash_model.sv
// Behavioural flash array and programming timer behind the block.
// Assumes the same clock; cycle length comes from delay_cycles.
`timescale 1ns/1ns
`default_nettype none
module spac_flash_model (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic [21:0]              flash_rd_addr,
  output logic [7:0]                   flash_rd_data,
  input wire spac_pkg::spac_prog_cmd_t prog_cmd,
  output logic                         prog_done,
  input wire logic [7:0]               delay_cycles
);
  logic [7:0] cnt;
  // Content mixes bit 21 in so the full address matters
  assign flash_rd_data = flash_rd_addr[7:0] ^ flash_rd_addr[15:8]
    ^ {flash_rd_addr[21], flash_rd_addr[20:14]};
  ////////////////////////////////////////////////////////////////////////////////
  // Self-timed cycle: one done pulse, slow or prompt by delay_cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00;
      prog_done <= 1'b0;
    end
    else
    begin
      prog_done <= (cnt == 8'h01);
      if (prog_cmd.start)
        cnt <= delay_cycles;
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench: APB master, reference model, flash partner.
// Assumes spac_pkg compiled first and the checker bound in.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serr;
  logic [7:0] paddr = 0, dly = 8'h04, lat;
  logic [31:0] pwdata = 0, prdata, rv;
  logic [21:0] flash_rd_addr, ptr;
  logic [7:0] flash_rd_data;
  logic pready, pslverr, prog_done, eeprom_rd_strobe, cpu_stall, nvm_done_flag;
  logic [511:0] hold_bytes, hm = '1;
  spac_pkg::spac_prog_cmd_t prog_cmd, lc;
  int n_fail = 0, num_checks = 0, n_st = 0, n_rs = 0, n_wait = 0;
  spac_access_ctrl spac_access_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data), .prog_cmd(prog_cmd), .prog_done(prog_done),
    .hold_bytes(hold_bytes), .eeprom_rd_strobe(eeprom_rd_strobe), .cpu_stall(cpu_stall),
    .nvm_done_flag(nvm_done_flag));
  spac_flash_model spac_flash_model_inst (.pclk(pclk), .presetn(presetn),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .prog_cmd(prog_cmd),
    .prog_done(prog_done), .delay_cycles(dly));
  always #2 pclk = ~pclk;
  // Event monitor at the falling edge, clear of register updates
  always @(negedge pclk)
  begin
    if (prog_cmd.start === 1'b1) begin n_st++; lc = prog_cmd; end
    if (eeprom_rd_strobe === 1'b1) n_rs++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] fl(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ {a[21], a[20:14]};
  endfunction
  // Steps wrap inside 21 bits; the top bit never moves
  function automatic logic [21:0] stp(input logic [21:0] p, input logic [20:0] d);
    return {p[21], p[20:0] + d};
  endfunction
  task automatic chk(input logic [511:0] g, input logic [511:0] e, input string m);
    num_checks++;
    if (g !== e) begin n_fail++; $display("mismatch at %0t: %s got %0h exp %0h", $time, m, g, e); end
  endtask
  // One APB transfer; pready, pslverr and prdata taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 300);
    if (pready !== 1'b1) chk(0, 1, "no pready");
    n_wait = k; serr = pslverr; rv = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0); chk(rv, e, "read");
  endtask
  task automatic rdp; rdc(spac_pkg::OFS_PTRL, ptr[7:0]); rdc(spac_pkg::OFS_PTRH, ptr[15:8]);
    rdc(spac_pkg::OFS_PTRU, ptr[21:16]); endtask
  task automatic setp(input logic [21:0] p); ptr = p; wr(spac_pkg::OFS_PTRL, p[7:0]);
    wr(spac_pkg::OFS_PTRH, p[15:8]); wr(spac_pkg::OFS_PTRU, p[21:16]); endtask
  // Table operation with model pointer update
  task automatic tbl(input logic [1:0] m, input logic w);
    logic [21:0] u = ptr;
    case (m)
      2'h1: ptr = stp(ptr, 21'h1);
      2'h2: ptr = stp(ptr, 21'h1FFFFF);
      2'h3: begin ptr = stp(ptr, 21'h1); u = ptr; end
      default: ;
    endcase
    if (w) hm[{u[5:0], 3'b000} +: 8] = lat; else lat = fl(u);
    wr(spac_pkg::OFS_TOP, {29'h0, w, m});
    if (!w) chk(flash_rd_addr, u, "read address");
    rdc(spac_pkg::OFS_LATCH, lat);
    rdp();
    chk(hold_bytes, hm, "holding bytes");
  endtask
  // Timed cycle attempt; ok only with unlock and permit
  task automatic cyc(input logic [7:0] c, input logic u);
    int n = n_st;
    logic ok = u && c[2];
    spac_pkg::spac_space_t s = c[6] ? spac_pkg::SPAC_SP_CONFIG
      : c[7] ? spac_pkg::SPAC_SP_FLASH : spac_pkg::SPAC_SP_EEPROM;
    dly <= 8'(2 + $urandom % 20);
    if (u) begin wr(spac_pkg::OFS_KEY, 32'h55); wr(spac_pkg::OFS_KEY, 32'hAA); end
    wr(spac_pkg::OFS_CTRL, c);
    // An access during a flash or config cycle must wait for the timer
    if (ok && s != spac_pkg::SPAC_SP_EEPROM)
    begin
      apb(1'b0, spac_pkg::OFS_DONE, 32'h0);
      chk(n_wait > dly, 1'b1, "stall too short");
    end
    repeat (40) @(posedge pclk);
    chk(n_st - n, ok, "cycle count");
    rdc(spac_pkg::OFS_CTRL, ok ? (c & 8'hC4) : ((c & 8'hD4) | 8'h08));
    rdc(spac_pkg::OFS_DONE, {ok, 6'h0});
    if (ok)
    begin
      chk({lc.space, lc.erase, lc.block}, {s, c[4], ptr[21:6]}, "command");
      wr(spac_pkg::OFS_DONE, 32'h40);
      rdc(spac_pkg::OFS_DONE, 32'h0);
      if (s == spac_pkg::SPAC_SP_FLASH && !c[4]) hm = '1;
      if (s == spac_pkg::SPAC_SP_FLASH) chk(hold_bytes, hm, "hold after cycle");
    end
  endtask
  task automatic rs(input logic [7:0] c, input int e);
    int n = n_rs;
    wr(spac_pkg::OFS_CTRL, c);
    repeat (3) @(posedge pclk);
    chk(n_rs - n, e, "read strobes");
    rdc(spac_pkg::OFS_CTRL, c & 8'hC4);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h41FA));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(spac_pkg::OFS_CTRL, 32'h08);
    wr(spac_pkg::OFS_KEY, 32'h55);
    rdc(spac_pkg::OFS_KEY, 32'h0);
    chk(hold_bytes, hm, "reset hold");
    apb(1'b0, 8'h20, 32'h0);
    chk(serr, 1'b1, "unmapped");
    setp(22'($urandom));
    for (int m = 0; m < 4; m++)
    begin
      lat = 8'($urandom);
      wr(spac_pkg::OFS_LATCH, lat);
      tbl(2'(m), 1'b1);
      tbl(2'(m), 1'b0);
    end
    setp(22'h3FFFFF);
    tbl(2'h1, 1'b0);
    tbl(2'h2, 1'b0);
    cyc(8'h86, 1'b0);
    setp({16'($urandom), 6'h2A});
    cyc(8'h96, 1'b1);
    cyc(8'h86, 1'b1);
    cyc(8'h82, 1'b1);
    cyc(8'hC6, 1'b1);
    cyc(8'h06, 1'b1);
    rs(8'h01, 1);
    rs(8'h81, 0);
    rs(8'h61, 0);
    complete_run();
  end
endmodule
`default_nettype wire
